// ### verilog/pis_pkg.sv
// shared constants and types for the identity string store
`default_nettype none
package pis_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_MAKER    = 8'h99;
  localparam logic [7:0] CODE_MODEL    = 8'h9a;
  localparam logic [7:0] CODE_REVISION = 8'h9b;
  localparam logic [7:0] CODE_LOCATION = 8'h9c;
  localparam logic [7:0] CODE_DATE     = 8'h9d;
  localparam logic [7:0] CODE_SERIAL   = 8'h9e;
  localparam logic [7:0] CODE_PART_ID  = 8'had;
  localparam logic [7:0] CODE_PART_REV = 8'hae;
  localparam logic [7:0] CODE_USER0    = 8'hb0;
  localparam logic [7:0] CODE_USER1    = 8'hb1;
  localparam logic [7:0] CODE_STORE    = 8'h15;
  localparam logic [7:0] CODE_RESTORE  = 8'h16;
  // ----------------------------------------------------------------
  // storage limits
  // ----------------------------------------------------------------
  localparam int         NUM_STR     = 8;
  localparam logic [7:0] STR_MAX     = 8'h20;
  localparam logic [9:0] BUDGET      = 10'h080;
  localparam logic [9:0] OVERHEAD    = 10'h001;
  localparam logic [7:0] WORD_LEN    = 8'h04;
  // arbitrary identity values, not those of any real part
  localparam logic [31:0] PART_ID_WORD  = 32'h00_5a_3c_7e;
  localparam logic [31:0] PART_REV_WORD = 32'h04_03_02_01;
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DEV_IDLE   = 5'h01,
    DEV_WDATA  = 5'h02,
    DEV_RCOUNT = 5'h04,
    DEV_RDATA  = 5'h08,
    DEV_DONE   = 5'h10
  } pis_dev_state_type;
  typedef enum logic [3:0] {
    HST_IDLE  = 4'h1,
    HST_REQ   = 4'h2,
    HST_WRITE = 4'h4,
    HST_WAIT  = 4'h8
  } pis_hst_state_type;
endpackage
`default_nettype wire

// ### verilog/pis_link_if.sv
// block command link between host and string store
`default_nettype none
interface pis_link_if;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_code;
  logic       req_write;
  logic [7:0] req_count;
  logic       wr_valid;
  logic [7:0] wr_byte;
  logic       rd_valid;
  logic [7:0] rd_byte;
  logic       rd_last;
  logic       done;
  logic       rejected;
  modport dev (
    input  req_valid, req_code, req_write, req_count, wr_valid, wr_byte,
    output req_ready, rd_valid, rd_byte, rd_last, done, rejected
  );
  modport host (
    output req_valid, req_code, req_write, req_count, wr_valid, wr_byte,
    input  req_ready, rd_valid, rd_byte, rd_last, done, rejected
  );
endinterface
`default_nettype wire

// ### verilog/pis_device.sv
// identity and user string store, device end of the block command link
`default_nettype none
module pis_device (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // link
  pis_link_if.dev         link,
  // status
  output logic      [7:0] used_bytes_o,
  output logic            store_req_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pis_pkg::pis_dev_state_type state_q;
  logic [7:0] mem_q [0:255];
  logic [7:0] len_q [0:7];
  logic [7:0] used_q;
  logic [7:0] cnt_q;
  logic [7:0] idx_q;
  logic [7:0] code_q;
  logic [2:0] slot_q;
  logic       ok_q;
  logic       rej_q;
  logic       is_word_q;
  logic       rd_valid_q;
  logic [7:0] rd_byte_q;
  logic       rd_last_q;
  logic       store_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic       str_hit;
  logic [2:0] str_slot;
  logic       word_hit;
  logic [9:0] need;
  logic [9:0] recount;
  logic       fits;

  always_comb begin
    str_hit  = 1'b1;
    str_slot = 3'h0;
    case (link.req_code)
      pis_pkg::CODE_MAKER:    str_slot = 3'h0;
      pis_pkg::CODE_MODEL:    str_slot = 3'h1;
      pis_pkg::CODE_REVISION: str_slot = 3'h2;
      pis_pkg::CODE_LOCATION: str_slot = 3'h3;
      pis_pkg::CODE_DATE:     str_slot = 3'h4;
      pis_pkg::CODE_SERIAL:   str_slot = 3'h5;
      pis_pkg::CODE_USER0:    str_slot = 3'h6;
      pis_pkg::CODE_USER1:    str_slot = 3'h7;
      default:                str_hit  = 1'b0;
    endcase
  end

  assign word_hit = (link.req_code == pis_pkg::CODE_PART_ID) ||
                    (link.req_code == pis_pkg::CODE_PART_REV);

  assign need = {2'h0, used_q} + {2'h0, link.req_count} + pis_pkg::OVERHEAD;
  assign fits = (link.req_count <= pis_pkg::STR_MAX) && (need <= pis_pkg::BUDGET);

  // bytes held by the committed strings, loaded into used_q when a restore is requested
  always_comb begin
    recount = 10'h000;
    for (int i = 0; i < pis_pkg::NUM_STR; i++) begin
      if (len_q[i] != 8'h00) begin
        recount = recount + {2'h0, len_q[i]} + pis_pkg::OVERHEAD;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q   <= pis_pkg::DEV_IDLE;
      cnt_q     <= 8'h00;
      idx_q     <= 8'h00;
      code_q    <= 8'h00;
      slot_q    <= 3'h0;
      ok_q      <= 1'b0;
      rej_q     <= 1'b0;
      is_word_q <= 1'b0;
    end else begin
      case (state_q)
        pis_pkg::DEV_IDLE: begin
          if (link.req_valid) begin
            code_q    <= link.req_code;
            slot_q    <= str_slot;
            idx_q     <= 8'h00;
            is_word_q <= 1'b0;
            if (link.req_write) begin
              cnt_q <= link.req_count;
              ok_q  <= str_hit && fits;
              rej_q <= !(str_hit && fits) &&
                       (link.req_code != pis_pkg::CODE_STORE) &&
                       (link.req_code != pis_pkg::CODE_RESTORE);
              if (link.req_count == 8'h00) begin
                state_q <= pis_pkg::DEV_DONE;
              end else begin
                state_q <= pis_pkg::DEV_WDATA;
              end
            end else if (str_hit) begin
              cnt_q   <= len_q[str_slot];
              ok_q    <= 1'b1;
              rej_q   <= 1'b0;
              state_q <= pis_pkg::DEV_RCOUNT;
            end else if (word_hit) begin
              cnt_q     <= pis_pkg::WORD_LEN;
              is_word_q <= 1'b1;
              ok_q      <= 1'b1;
              rej_q     <= 1'b0;
              state_q   <= pis_pkg::DEV_RCOUNT;
            end else begin
              ok_q    <= 1'b0;
              rej_q   <= 1'b1;
              state_q <= pis_pkg::DEV_DONE;
            end
          end
        end
        pis_pkg::DEV_WDATA: begin
          if (link.wr_valid) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == cnt_q - 8'h01) begin
              state_q <= pis_pkg::DEV_DONE;
            end
          end
        end
        pis_pkg::DEV_RCOUNT: begin
          if (cnt_q == 8'h00) begin
            state_q <= pis_pkg::DEV_DONE;
          end else begin
            state_q <= pis_pkg::DEV_RDATA;
          end
        end
        pis_pkg::DEV_RDATA: begin
          idx_q <= idx_q + 8'h01;
          if (idx_q == cnt_q - 8'h01) begin
            state_q <= pis_pkg::DEV_DONE;
          end
        end
        pis_pkg::DEV_DONE: begin
          state_q <= pis_pkg::DEV_IDLE;
        end
        default: begin
          state_q <= pis_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // string storage
  // ----------------------------------------------------------------
  // bytes stored as written
  always_ff @(posedge clk_sys_i) begin
    if (state_q == pis_pkg::DEV_WDATA && link.wr_valid && ok_q) begin
      mem_q[{slot_q, idx_q[4:0]}] <= link.wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // lengths and shared budget
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < pis_pkg::NUM_STR; i++) begin
        len_q[i] <= 8'h00;
      end
      used_q  <= 8'h00;
      store_q <= 1'b0;
    end else begin
      store_q <= 1'b0;
      if (state_q == pis_pkg::DEV_IDLE && link.req_valid && link.req_write) begin
        if (str_hit && fits) begin
          // rejected writes leave the string alone
          len_q[str_slot] <= link.req_count;
          // each write charged, not just the last
          used_q <= need[7:0];
        end else if (link.req_code == pis_pkg::CODE_RESTORE) begin
          // restore drops charges of superseded writes
          used_q <= recount[7:0];
        end else if (link.req_code == pis_pkg::CODE_STORE) begin
          store_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [31:0] word_sel;
  assign word_sel = (code_q == pis_pkg::CODE_PART_ID) ? pis_pkg::PART_ID_WORD
                                                      : pis_pkg::PART_REV_WORD;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd_byte_q  <= 8'h00;
      rd_last_q  <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      rd_last_q  <= 1'b0;
      if (state_q == pis_pkg::DEV_RCOUNT) begin
        rd_valid_q <= 1'b1;
        rd_byte_q  <= cnt_q;
        rd_last_q  <= (cnt_q == 8'h00);
      end else if (state_q == pis_pkg::DEV_RDATA) begin
        rd_valid_q <= 1'b1;
        rd_last_q  <= (idx_q == cnt_q - 8'h01);
        if (is_word_q) begin
          // byte 0 first from low end
          rd_byte_q <= word_sel[{idx_q[1:0], 3'h0} +: 8];
        end else begin
          rd_byte_q <= mem_q[{slot_q, idx_q[4:0]}];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.req_ready = (state_q == pis_pkg::DEV_IDLE);
  assign link.rd_valid  = rd_valid_q;
  assign link.rd_byte   = rd_byte_q;
  assign link.rd_last   = rd_last_q;
  assign link.done      = (state_q == pis_pkg::DEV_DONE);
  assign link.rejected  = (state_q == pis_pkg::DEV_DONE) && rej_q;
  assign used_bytes_o   = used_q;
  assign store_req_o    = store_q;

endmodule
`default_nettype wire

// ### verilog/pis_host.sv
// host end of the block command link, with reclaim sequencing
`default_nettype none
module pis_host (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // link
  pis_link_if.host        link,
  // user command
  input  wire logic       start_i,
  input  wire logic       reclaim_i,
  input  wire logic [7:0] code_i,
  input  wire logic       write_i,
  input  wire logic [7:0] count_i,
  // user write data
  input  wire logic [7:0] data_i,
  output logic            data_take_o,
  // user read data and status
  output logic            rd_valid_o,
  output logic      [7:0] rd_byte_o,
  output logic            rd_last_o,
  output logic            done_o,
  output logic            rejected_o,
  output logic            busy_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pis_pkg::pis_hst_state_type state_q;
  logic [7:0] code_q;
  logic       write_q;
  logic [7:0] count_q;
  logic [7:0] left_q;
  logic       reclaim_q;
  logic [1:0] step_q;
  logic       wr_valid_q;
  logic [7:0] wr_byte_q;
  logic       rd_valid_q;
  logic [7:0] rd_byte_q;
  logic       rd_last_q;
  logic       done_q;
  logic       rej_q;
  logic [7:0] cur_code;
  logic [7:0] cur_count;

  always_comb begin
    cur_code  = code_q;
    cur_count = count_q;
    if (reclaim_q) begin
      case (step_q)
        2'h0:    cur_code = pis_pkg::CODE_RESTORE;
        2'h2:    cur_code = pis_pkg::CODE_STORE;
        2'h3:    cur_code = pis_pkg::CODE_RESTORE;
        default: cur_code = code_q;
      endcase
      if (step_q != 2'h1) begin
        cur_count = 8'h00;
      end
    end
  end

  assign data_take_o = (state_q == pis_pkg::HST_WRITE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q    <= pis_pkg::HST_IDLE;
      code_q     <= 8'h00;
      write_q    <= 1'b0;
      count_q    <= 8'h00;
      left_q     <= 8'h00;
      reclaim_q  <= 1'b0;
      step_q     <= 2'h0;
      wr_valid_q <= 1'b0;
      wr_byte_q  <= 8'h00;
      done_q     <= 1'b0;
      rej_q      <= 1'b0;
    end else begin
      wr_valid_q <= 1'b0;
      done_q     <= 1'b0;
      case (state_q)
        pis_pkg::HST_IDLE: begin
          if (start_i || reclaim_i) begin
            code_q    <= code_i;
            write_q   <= write_i || reclaim_i;
            count_q   <= count_i;
            reclaim_q <= reclaim_i;
            step_q    <= 2'h0;
            rej_q     <= 1'b0;
            state_q   <= pis_pkg::HST_REQ;
          end
        end
        pis_pkg::HST_REQ: begin
          if (link.req_ready) begin
            left_q <= cur_count;
            if (write_q && cur_count != 8'h00) begin
              state_q <= pis_pkg::HST_WRITE;
            end else begin
              state_q <= pis_pkg::HST_WAIT;
            end
          end
        end
        pis_pkg::HST_WRITE: begin
          wr_valid_q <= 1'b1;
          wr_byte_q  <= data_i;
          left_q     <= left_q - 8'h01;
          if (left_q == 8'h01) begin
            state_q <= pis_pkg::HST_WAIT;
          end
        end
        pis_pkg::HST_WAIT: begin
          if (link.done) begin
            rej_q <= rej_q || link.rejected;
            if (reclaim_q && step_q != 2'h3) begin
              step_q  <= step_q + 2'h1;
              state_q <= pis_pkg::HST_REQ;
            end else begin
              done_q  <= 1'b1;
              state_q <= pis_pkg::HST_IDLE;
            end
          end
        end
        default: begin
          state_q <= pis_pkg::HST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd_byte_q  <= 8'h00;
      rd_last_q  <= 1'b0;
    end else begin
      rd_valid_q <= link.rd_valid;
      rd_byte_q  <= link.rd_byte;
      rd_last_q  <= link.rd_valid && link.rd_last;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // caller keeps counts in limits; device refuses otherwise
  assign link.req_valid = (state_q == pis_pkg::HST_REQ);
  assign link.req_code  = cur_code;
  assign link.req_write = write_q;
  assign link.req_count = cur_count;
  assign link.wr_valid  = wr_valid_q;
  assign link.wr_byte   = wr_byte_q;
  assign rd_valid_o     = rd_valid_q;
  assign rd_byte_o      = rd_byte_q;
  assign rd_last_o      = rd_last_q;
  assign done_o         = done_q;
  assign rejected_o     = done_q && rej_q;
  assign busy_o         = (state_q != pis_pkg::HST_IDLE);

endmodule
`default_nettype wire

// ### tb/pis_link_properties.sv
// concurrent checks on the block command link
`default_nettype none
module pis_link_properties (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  // link signals
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_code,
  input wire logic       req_write,
  input wire logic [7:0] req_count,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_last,
  input wire logic       done,
  input wire logic       rejected
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ----
  // helper: last taken request
  // ----
  logic       tk;
  logic       wr_q;
  logic [7:0] cnt_q;
  assign tk = req_valid && req_ready;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_q  <= 1'b0;
      cnt_q <= 8'h00;
    end else if (tk) begin
      wr_q  <= req_write;
      cnt_q <= req_count;
    end
  end
  // ----
  // properties
  // ----
  property p_rst_idle;
    $fell(rst_i) |-> req_ready && !done && !rd_valid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_rej_done;
    rejected |-> done;
  endproperty
  a_rej_done: assert property (p_rej_done) else $error("rejected without done");
  property p_last;
    rd_last |-> rd_valid && done;
  endproperty
  a_last: assert property (p_last) else $error("last byte not with done");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_taken;
    tk |=> !req_ready;
  endproperty
  a_taken: assert property (p_taken) else $error("ready high after request taken");
  property p_ready_back;
    done |=> req_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready low after done");
  property p_ro_write;
    tk && req_write && req_count == 8'h00 && (req_code == pis_pkg::CODE_PART_ID
      || req_code == pis_pkg::CODE_PART_REV) |=> done && rejected;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("word write not refused");
  property p_id_read;
    tk && !req_write && req_code == pis_pkg::CODE_PART_ID |-> ##2 rd_valid
      && rd_byte == pis_pkg::WORD_LEN
      ##1 rd_valid && rd_byte == pis_pkg::PART_ID_WORD[7:0]
      ##1 rd_valid && rd_byte == pis_pkg::PART_ID_WORD[15:8]
      ##1 rd_valid && rd_byte == pis_pkg::PART_ID_WORD[23:16]
      ##1 rd_valid && rd_byte == pis_pkg::PART_ID_WORD[31:24] && rd_last && done;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity word read wrong");
  property p_rev_read;
    tk && !req_write && req_code == pis_pkg::CODE_PART_REV |-> ##2 rd_valid
      && rd_byte == pis_pkg::WORD_LEN
      ##1 rd_valid && rd_byte == pis_pkg::PART_REV_WORD[7:0]
      ##1 rd_valid && rd_byte == pis_pkg::PART_REV_WORD[15:8]
      ##1 rd_valid && rd_byte == pis_pkg::PART_REV_WORD[23:16]
      ##1 rd_valid && rd_byte == pis_pkg::PART_REV_WORD[31:24] && rd_last && done;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision word read wrong");
  property p_oversize;
    done && wr_q && cnt_q > pis_pkg::STR_MAX |-> rejected;
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize write accepted");
endmodule
`default_nettype wire

// ### tb/pmbus_identity_string_store_tb_top.sv
// self-checking bench: host and string store joined by the link
`default_nettype none
module pmbus_identity_string_store_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i;
  logic       rst_i;
  logic       start_i;
  logic       reclaim_i;
  logic [7:0] code_i;
  logic       write_i;
  logic [7:0] count_i;
  logic [7:0] data_i;
  logic       data_take_o;
  logic       rd_valid_o;
  logic [7:0] rd_byte_o;
  logic       rd_last_o;
  logic       done_o;
  logic       rejected_o;
  logic       busy_o;
  logic [7:0] used_bytes_o;
  logic       store_req_o;
  logic [7:0] wbuf [0:39];
  logic [7:0] rbuf [$];
  logic       last_seen;
  int         widx;
  int         stores;
  int         errors;
  int         samples_checked;
  pis_link_if pis_link_if_i ();
  pis_device pis_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(pis_link_if_i),
    .used_bytes_o(used_bytes_o), .store_req_o(store_req_o));
  pis_host pis_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(pis_link_if_i),
    .start_i(start_i), .reclaim_i(reclaim_i), .code_i(code_i), .write_i(write_i),
    .count_i(count_i), .data_i(data_i), .data_take_o(data_take_o),
    .rd_valid_o(rd_valid_o), .rd_byte_o(rd_byte_o), .rd_last_o(rd_last_o),
    .done_o(done_o), .rejected_o(rejected_o), .busy_o(busy_o));
  pis_link_properties pis_link_properties_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .req_valid(pis_link_if_i.req_valid), .req_ready(pis_link_if_i.req_ready),
    .req_code(pis_link_if_i.req_code), .req_write(pis_link_if_i.req_write),
    .req_count(pis_link_if_i.req_count), .rd_valid(pis_link_if_i.rd_valid),
    .rd_byte(pis_link_if_i.rd_byte), .rd_last(pis_link_if_i.rd_last),
    .done(pis_link_if_i.done), .rejected(pis_link_if_i.rejected));
  // ----
  // clock, data feed, read capture
  // ----
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    if (data_take_o) begin
      data_i <= wbuf[widx];
      widx   <= widx + 1;
    end
    if (rd_valid_o) begin
      rbuf.push_back(rd_byte_o);
      last_seen = rd_last_o;
    end
    if (store_req_o) stores++;
  end
  // ----
  // tasks
  // ----
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task summarize;
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task run(input logic [7:0] c, input logic w, input logic [7:0] n, input logic rej,
           input logic rc);
    int k;
    @(negedge clk_sys_i);
    rbuf.delete();
    last_seen = 1'b0;
    widx = 0;
    code_i = c;
    write_i = w;
    count_i = n;
    start_i = !rc;
    reclaim_i = rc;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    reclaim_i = 1'b0;
    chk("busy", busy_o, 1'b1);
    k = 0;
    while (done_o !== 1'b1 && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk("done", done_o, 1'b1);
    chk("rejected", rejected_o, rej);
    @(negedge clk_sys_i);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] n, input logic [7:0] b, input logic rej,
          input logic rc = 1'b0);
    for (int i = 0; i < 40; i++) wbuf[i] = b + 8'(i);
    run(c, 1'b1, n, rej, rc);
  endtask
  task rd(input logic [7:0] c, input logic [7:0] n, input logic [7:0] b);
    run(c, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("count", rbuf[0], n);
    chk("last", last_seen, 1'b1);
    for (int i = 0; i < n; i++) chk("byte", rbuf[i+1], b + 8'(i));
  endtask
  task rdw(input logic [7:0] c, input logic [31:0] w);
    run(c, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("wcount", rbuf[0], pis_pkg::WORD_LEN);
    for (int i = 0; i < 4; i++) chk("wbyte", rbuf[i+1], w[8*i+:8]);
  endtask
  // ----
  // sequence and watchdog
  // ----
  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    reclaim_i = 1'b0;
    code_i = 8'h00;
    write_i = 1'b0;
    count_i = 8'h00;
    data_i = 8'h00;
    widx = 0;
    stores = 0;
    errors = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(i < 6 ? pis_pkg::CODE_MAKER + 8'(i) : pis_pkg::CODE_USER0 + 8'(i - 6), 0, 0);
    chk("used", used_bytes_o, 8'h00);
    rdw(pis_pkg::CODE_PART_ID, pis_pkg::PART_ID_WORD);
    rdw(pis_pkg::CODE_PART_REV, pis_pkg::PART_REV_WORD);
    wr(pis_pkg::CODE_PART_ID, 8'h03, 8'h30, 1'b1);
    wr(pis_pkg::CODE_PART_REV, 8'h00, 8'h30, 1'b1);
    rdw(pis_pkg::CODE_PART_ID, pis_pkg::PART_ID_WORD);
    wr(pis_pkg::CODE_MAKER, 8'h20, 8'ha0, 1'b0);
    rd(pis_pkg::CODE_MAKER, 8'h20, 8'ha0);
    wr(pis_pkg::CODE_MODEL, 8'h21, 8'h41, 1'b1);
    rd(pis_pkg::CODE_MODEL, 8'h00, 8'h00);
    wr(pis_pkg::CODE_MAKER, 8'h21, 8'h41, 1'b1);
    rd(pis_pkg::CODE_MAKER, 8'h20, 8'ha0);
    wr(pis_pkg::CODE_RESTORE, 8'h00, 8'h00, 1'b0);
    chk("used", used_bytes_o, 8'd33);
    wr(pis_pkg::CODE_REVISION, 8'd20, 8'he0, 1'b0);
    chk("used", used_bytes_o, 8'd54);
    wr(pis_pkg::CODE_REVISION, 8'd20, 8'h61, 1'b0);
    chk("used", used_bytes_o, 8'd75);
    rd(pis_pkg::CODE_REVISION, 8'd20, 8'h61);
    wr(pis_pkg::CODE_LOCATION, 8'd31, 8'hc0, 1'b0);
    wr(pis_pkg::CODE_DATE, 8'd20, 8'h30, 1'b0);
    chk("used", used_bytes_o, 8'd128);
    wr(pis_pkg::CODE_SERIAL, 8'h00, 8'h00, 1'b1);
    wr(pis_pkg::CODE_REVISION, 8'd5, 8'h70, 1'b0, 1'b1);
    chk("used", used_bytes_o, 8'd92);
    chk("stores", stores, 1);
    rd(pis_pkg::CODE_REVISION, 8'd5, 8'h70);
    wr(pis_pkg::CODE_USER0, 8'd3, 8'h21, 1'b0);
    rd(pis_pkg::CODE_USER0, 8'd3, 8'h21);
    wr(pis_pkg::CODE_USER1, 8'd1, 8'hff, 1'b0);
    rd(pis_pkg::CODE_USER1, 8'd1, 8'hff);
    chk("used", used_bytes_o, 8'd98);
    wr(pis_pkg::CODE_MAKER, 8'h00, 8'h00, 1'b0);
    rd(pis_pkg::CODE_MAKER, 8'h00, 8'h00);
    run(8'h98, 1'b0, 8'h00, 1'b1, 1'b0);
    // second reset in mid-run, with strings held
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("used", used_bytes_o, 8'h00);
    rd(pis_pkg::CODE_USER0, 8'h00, 8'h00);
    wr(pis_pkg::CODE_STORE, 8'h00, 8'h00, 1'b0);
    chk("stores", stores, 2);
    summarize();
  end
endmodule
`default_nettype wire
